// File: verilog/pmu_seq_consts.svh
// Constants for the power mode sequencer: timing, strap codes, slots
`ifndef PMU_SEQ_CONSTS_SVH
`define PMU_SEQ_CONSTS_SVH

// System clock period
`define CLK_PERIOD_NS 10
// Reference and bias settling, nominal figure
`define BIAS_SETTLE_US 150
// Spacing between sequence points
`define TIME_STEP_US 25
// Longest power-on-reset process
`define POR_MAX_US 500
// Serial slave address per address strap level
`define ADDR_STRAP_HIGH 7'h7f
`define ADDR_STRAP_FLOAT 7'h7c
`define ADDR_STRAP_LOW 7'h7d
// Sequence slot codes
`define SLOT_FIRST 3'h0
`define SLOT_LAST 3'h6
`define SLOT_EXCLUDED 3'h7
// Cycles for the strap senses to settle after supply is good
`define STRAP_SETTLE 3'h4
// Interrupt flag positions
`define INT_TRIP_BIT 1
`define INT_EW_BIT 0

`endif

// File: verilog/pmu_seq_pkg.sv
// Types shared by the power mode sequencer
package pmu_seq_pkg;

  typedef enum logic [3:0] {
    st_por_wait,
    st_strap_settle,
    st_load,
    st_standby,
    st_bias,
    st_startup,
    st_idle,
    st_shutdown,
    st_restore_aux,
    st_restore_main
  } mode_t;

  typedef enum logic [1:0] {
    strap_low,
    strap_float,
    strap_high
  } strap_t;

  typedef enum logic [1:0] {
    profile_one,
    profile_two,
    profile_three
  } profile_t;

endpackage : pmu_seq_pkg

// File: verilog/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] pin_in, // Asynchronous pin levels
  output logic [WIDTH-1:0] pin_out // Filtered synchronous levels
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] out_reg;
  wire [WIDTH-1:0] agree = ~(stage2_reg ^ stage3_reg);

  // A change is taken once the second and third stages agree
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      out_reg <= '0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      out_reg <= (agree & stage3_reg) | (~agree & out_reg);
    end
  end

  assign pin_out = out_reg;

endmodule : pin_sync

`default_nettype wire

// File: verilog/step_timer.sv
// Down-counter that pulses done a loaded number of cycles after load
`timescale 1ns/1ps
`default_nettype none

module step_timer #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic load, // Restart the count, one-cycle pulse
  input wire logic [WIDTH-1:0] value, // Cycles until done
  output logic done // One-cycle pulse at expiry
);

  logic [WIDTH-1:0] cnt_reg;
  logic done_reg;
  wire last_tick = (cnt_reg == WIDTH'(1));

  // Count down to zero; done follows the last tick by one edge
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      if (load) begin
        cnt_reg <= value;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - WIDTH'(1);
      end
      done_reg <= last_tick && !load;
    end
  end

  assign done = done_reg;

  a_no_early_done: assert property (@(posedge sys_clk) disable iff (!rstn)
    load |=> !done) else $error("timer done right after load");

endmodule : step_timer

`default_nettype wire

// File: verilog/pmu_mode_sequencer.sv
// Power mode sequencer: reset, standby, start-up, idle, shut-down
// Operation
// - After supply good, sample straps, load defaults, enter standby within 500 us.
// - Standby keeps only the serial interface alive; all regulators off.
// - Start-up on enable rising, or thermal trip clearing while enable is high.
// - After start-up enter idle; regulators then follow their enable bits.
// - Shut-down runs the start-up slots in reverse, read from register contents.
// - Shut-down on enable falling or thermal trip.
// - Address strap high, floating, low gives address 7F, 7C, 7D.
// - Profile strap high, low, floating selects setup one, two, three.
// - Select pin high uses the first step-down set, low the second.
// - Step-down set choice comes from a serial setting or the pin.
// - Sleep is entered by serial command or by the select pin.
// - Unmasked thermal warning or trip events drive the interrupt low.
// - Reading the interrupt register releases the interrupt.
// - Wait bias settling, 150 us nominal, before the first enable point.
// - Sequence points are spaced by a 25 us step.
// - Unsequenced regulators switch off at once on enable falling.
// - Same immediate switch-off for all unsequenced outputs under profile two.
// - A shut-down point restores pull-down and interrupt-mask defaults.
// - A later shut-down point restores the registers 0x00 to 0x08.
// - Default slots put regulators one to four together, or three alone.
`timescale 1ns/1ps
`default_nettype none
`include "pmu_seq_consts.svh"

module pmu_mode_sequencer
  import pmu_seq_pkg::*;
#(
  parameter int NUM_REGS = 6,
  parameter int unsigned BIAS_CYCLES =
    (`BIAS_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic sys_clk, // 100 MHz oscillator clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic battery_supply_ok, // Supply above upper threshold
  input wire logic enable_pin, // Enable pin level
  input wire logic thermal_trip, // Die above trip threshold
  input wire logic thermal_early_warning, // Early warning crossed
  input wire logic voltage_set_select, // Select pin level
  input wire logic default_profile_strap_high, // Profile strap reads high
  input wire logic default_profile_strap_low, // Profile strap reads low
  input wire logic bus_address_strap_high, // Address strap reads high
  input wire logic bus_address_strap_low, // Address strap reads low
  input wire logic [NUM_REGS-1:0] reg_enable_bits, // Enable bit per reg
  input wire logic [3*NUM_REGS-1:0] slot_codes, // Slot code per reg
  input wire logic ext_dvs_control, // Pin steers the set choice
  input wire logic ext_sleep_control, // Pin steers sleep
  input wire logic serial_high_set, // Serial choice of first set
  input wire logic serial_sleep, // Serial sleep request
  input wire logic [1:0] int_mask, // Interrupt masks, 1 masks
  input wire logic int_read, // Interrupt register read pulse
  output var mode_t power_mode, // Current mode
  output logic [NUM_REGS-1:0] regulator_on, // Regulator enables
  output logic defaults_load, // Load all register defaults
  output var profile_t default_profile, // Strapped profile
  output logic [6:0] bus_address, // Strapped slave address
  output logic restore_aux_defaults, // Restore pull-down and mask
  output logic restore_main_defaults, // Restore registers 0x00..0x08
  output logic use_high_set, // Step-down uses first set
  output logic sleep_active, // Low-quiescent sleep
  output logic irq_n_out, // Interrupt pin drive level
  output logic irq_n_oe, // Interrupt pin pulled low
  output logic [1:0] int_flags, // Sticky interrupt flags
  output logic [1:0] thermal_status // Live trip and warning
);

  localparam logic [15:0] STEP_CYCLES =
    16'((`TIME_STEP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [15:0] BIAS_COUNT = 16'(BIAS_CYCLES);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Regulators whose slot code equals k
  function automatic logic [NUM_REGS-1:0] slot_match(
    input logic [3*NUM_REGS-1:0] codes, input logic [2:0] k);
    logic [NUM_REGS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      m[i] = (codes[3*i +: 3] == k);
    end
    return m;
  endfunction : slot_match

  // Three-level strap from its two sense inputs
  function automatic strap_t strap_decode(input logic hi, input logic lo);
    strap_t s;
    s = strap_float;
    if (hi) begin
      s = strap_high;
    end else if (lo) begin
      s = strap_low;
    end
    return s;
  endfunction : strap_decode

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [8:0] sync_out;
  pin_sync #(.WIDTH(9)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in({battery_supply_ok, enable_pin, thermal_trip,
             thermal_early_warning, voltage_set_select,
             default_profile_strap_high, default_profile_strap_low,
             bus_address_strap_high, bus_address_strap_low}),
    .pin_out(sync_out)
  );

  wire bat_s = sync_out[8];
  wire en_s = sync_out[7];
  wire trip_s = sync_out[6];
  wire ew_s = sync_out[5];
  wire dvs_s = sync_out[4];

  ////////////////////////////////////////////////////////////////////////
  // State

  mode_t mode_reg;
  mode_t mode_next;
  logic [2:0] ptr_reg;
  logic [2:0] ptr_next;
  logic [NUM_REGS-1:0] on_reg;
  logic [NUM_REGS-1:0] on_next;
  logic [2:0] settle_reg;
  logic en_prev_reg;
  logic trip_prev_reg;
  logic ew_prev_reg;
  logic [1:0] flags_reg;
  logic irq_oe_reg;
  logic defaults_load_reg;
  logic restore_aux_reg;
  logic restore_main_reg;
  logic high_set_reg;
  logic sleep_reg;
  profile_t profile_reg;
  logic [6:0] address_reg;
  logic [1:0] status_reg;
  logic [15:0] step_cnt_reg;
  logic timer_load;
  logic [15:0] timer_value;
  logic timer_done;

  // Edge detection on synchronised levels
  wire en_rise = en_s && !en_prev_reg;
  wire en_fall = !en_s && en_prev_reg;
  wire trip_rise = trip_s && !trip_prev_reg;
  wire trip_fall = !trip_s && trip_prev_reg;
  wire ew_rise = ew_s && !ew_prev_reg;
  wire in_active = (mode_reg == st_bias) || (mode_reg == st_startup) ||
                   (mode_reg == st_idle);
  wire start_trig = (mode_reg == st_standby) &&
                    ((en_rise && !trip_s) || (trip_fall && en_s));
  wire stop_trig = in_active && (en_fall || trip_s);
  wire [NUM_REGS-1:0] excl_mask = slot_match(slot_codes, `SLOT_EXCLUDED);
  wire [NUM_REGS-1:0] ptr_mask = slot_match(slot_codes, ptr_reg);
  wire [NUM_REGS-1:0] first_mask = slot_match(slot_codes, `SLOT_FIRST);

  step_timer #(.WIDTH(16)) u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(timer_load),
    .value(timer_value),
    .done(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencing

  always_comb begin
    mode_next = mode_reg;
    ptr_next = ptr_reg;
    on_next = on_reg;
    timer_load = 1'b0;
    timer_value = STEP_CYCLES;
    unique case (mode_reg)
      st_por_wait: begin
        on_next = '0;
        if (bat_s) mode_next = st_strap_settle;
      end
      st_strap_settle: begin
        if (settle_reg == `STRAP_SETTLE) mode_next = st_load;
      end
      st_load: mode_next = st_standby;
      st_standby: begin
        on_next = '0;
        if (start_trig) begin
          mode_next = st_bias;
          timer_load = 1'b1;
          timer_value = BIAS_COUNT;
        end
      end
      st_bias: begin
        if (timer_done) begin
          on_next = on_reg | (reg_enable_bits & first_mask);
          ptr_next = `SLOT_FIRST + 3'h1;
          timer_load = 1'b1;
          mode_next = st_startup;
        end
      end
      st_startup: begin
        if (timer_done) begin
          on_next = on_reg | (reg_enable_bits & ptr_mask);
          if (ptr_reg == `SLOT_LAST) begin
            mode_next = st_idle;
          end else begin
            ptr_next = ptr_reg + 3'h1;
            timer_load = 1'b1;
          end
        end
      end
      st_idle: on_next = reg_enable_bits;
      st_shutdown: begin
        if (timer_done) begin
          on_next = on_reg & ~ptr_mask;
          timer_load = 1'b1;
          if (ptr_reg == `SLOT_FIRST) begin
            mode_next = st_restore_aux;
          end else begin
            ptr_next = ptr_reg - 3'h1;
          end
        end
      end
      st_restore_aux: begin
        if (timer_done) begin
          mode_next = st_restore_main;
          timer_load = 1'b1;
        end
      end
      st_restore_main: begin
        if (timer_done) mode_next = st_standby;
      end
    endcase
    if (stop_trig) begin
      mode_next = st_shutdown;
      on_next = on_reg & ~excl_mask;
      ptr_next = `SLOT_LAST;
      timer_load = 1'b1;
    end
    if (!bat_s) begin
      mode_next = st_por_wait;
      on_next = '0;
    end
  end

  // Flag set wins over the read that clears it
  wire [1:0] flag_set = {trip_rise, ew_rise};
  wire [1:0] flags_next = (flags_reg & ~{2{int_read}}) | flag_set;
  wire irq_next = |(flags_next & ~int_mask);
  wire high_set_next = ext_dvs_control ? dvs_s : serial_high_set;
  wire sleep_next = (mode_next == st_idle) &&
                    (ext_sleep_control ? !dvs_s : serial_sleep);
  wire aux_next = (mode_reg == st_restore_aux) && timer_done;
  wire main_next = (mode_reg == st_restore_main) && timer_done;
  wire strap_take = (mode_reg == st_strap_settle) && (mode_next == st_load);
  strap_t prof_strap;
  strap_t addr_strap;
  assign prof_strap = strap_decode(sync_out[3], sync_out[2]);
  assign addr_strap = strap_decode(sync_out[1], sync_out[0]);
  wire [6:0] addr_next = (addr_strap == strap_high) ? `ADDR_STRAP_HIGH :
                         (addr_strap == strap_low) ? `ADDR_STRAP_LOW :
                         `ADDR_STRAP_FLOAT;
  profile_t prof_next;
  assign prof_next = (prof_strap == strap_high) ? profile_one :
                     (prof_strap == strap_low) ? profile_two :
                     profile_three;

  // Sequencer state
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode_reg <= st_por_wait;
      ptr_reg <= `SLOT_FIRST;
      on_reg <= '0;
      settle_reg <= 3'h0;
      step_cnt_reg <= 16'h0000;
    end else begin
      mode_reg <= mode_next;
      ptr_reg <= ptr_next;
      on_reg <= on_next;
      settle_reg <= (mode_reg == st_strap_settle) ? settle_reg + 3'h1 : 3'h0;
      step_cnt_reg <= timer_load ? 16'h0000 : step_cnt_reg + 16'h0001;
    end
  end

  // Straps and pulses
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      profile_reg <= profile_one;
      address_reg <= `ADDR_STRAP_FLOAT;
      defaults_load_reg <= 1'b0;
      restore_aux_reg <= 1'b0;
      restore_main_reg <= 1'b0;
    end else begin
      if (strap_take) profile_reg <= prof_next;
      if (strap_take) address_reg <= addr_next;
      defaults_load_reg <= (mode_reg == st_load);
      restore_aux_reg <= aux_next;
      restore_main_reg <= main_next;
    end
  end

  // Thermal, interrupt and step-down controls
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      en_prev_reg <= 1'b0;
      trip_prev_reg <= 1'b0;
      ew_prev_reg <= 1'b0;
      flags_reg <= 2'h0;
      irq_oe_reg <= 1'b0;
      high_set_reg <= 1'b0;
      sleep_reg <= 1'b0;
      status_reg <= 2'h0;
    end else begin
      en_prev_reg <= en_s;
      trip_prev_reg <= trip_s;
      ew_prev_reg <= ew_s;
      flags_reg <= flags_next;
      irq_oe_reg <= irq_next;
      high_set_reg <= high_set_next;
      sleep_reg <= sleep_next;
      status_reg <= {trip_s, ew_s};
    end
  end

  assign power_mode = mode_reg;
  assign regulator_on = on_reg;
  assign defaults_load = defaults_load_reg;
  assign default_profile = profile_reg;
  assign bus_address = address_reg;
  assign restore_aux_defaults = restore_aux_reg;
  assign restore_main_defaults = restore_main_reg;
  assign use_high_set = high_set_reg;
  assign sleep_active = sleep_reg;
  assign irq_n_out = 1'b0; // Open drain only ever pulls low
  assign irq_n_oe = irq_oe_reg;
  assign int_flags = flags_reg;
  assign thermal_status = status_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_por_to_standby: assert property ((mode_reg == st_load) && bat_s |=>
    defaults_load_reg && (mode_reg == st_standby)) else $error("no standby");
  a_standby_all_off: assert property ((mode_reg == st_standby) |->
    on_reg == '0) else $error("regulator on in standby");
  a_start_trigger: assert property (start_trig && bat_s |=>
    mode_reg == st_bias) else $error("start-up not begun");
  a_idle_follows: assert property ((mode_reg == st_idle) && !stop_trig &&
    bat_s |=> on_reg == $past(reg_enable_bits))
    else $error("idle enables not followed");
  a_stop_trigger: assert property (stop_trig && bat_s |=>
    mode_reg == st_shutdown) else $error("shut-down not begun");
  a_excluded_off: assert property (stop_trig && bat_s |=>
    (on_reg & $past(excl_mask)) == '0) else $error("unsequenced still on");
  a_bias_wait: assert property ((mode_reg == st_bias) && timer_done |->
    step_cnt_reg == BIAS_COUNT) else $error("bias wait wrong");
  a_step_spacing: assert property (timer_done && (mode_reg == st_startup ||
    mode_reg == st_shutdown) |-> step_cnt_reg == STEP_CYCLES)
    else $error("step spacing wrong");
  a_irq_raise: assert property (trip_rise && !int_mask[`INT_TRIP_BIT] |=>
    irq_oe_reg) else $error("interrupt not raised");
  a_irq_release: assert property (int_read && !trip_rise && !ew_rise |=>
    !irq_oe_reg) else $error("interrupt not released");
  a_dvs_pin: assert property (ext_dvs_control |=>
    high_set_reg == $past(dvs_s)) else $error("set choice wrong");
  a_restore_order: assert property (restore_main_reg |->
    mode_reg == st_standby || !bat_s) else $error("restore out of order");
  a_restore_aux: assert property (restore_aux_reg |->
    on_reg == '0) else $error("restore while regulators on");

  c_reach_idle: cover property ((mode_reg == st_startup) ##1
    (mode_reg == st_idle));
  c_full_shutdown: cover property (restore_main_reg);
  c_irq: cover property ($rose(irq_oe_reg));
  c_sleep: cover property ($rose(sleep_reg));

endmodule : pmu_mode_sequencer

`default_nettype wire

// File: verilog/unused_placeholder_none.sv
// Empty marker module file intentionally minimal
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: verification/host_model.sv
// Host controller model: register image, control bits, interrupt reads
`timescale 1ns/1ps
`default_nettype none

module host_model
  import pmu_seq_pkg::*;
(
  input wire logic sys_clk, // System clock
  input var mode_t power_mode, // Sequencer mode
  input var profile_t default_profile, // Strapped profile
  input wire logic defaults_load, // Load defaults pulse
  input wire logic restore_aux_defaults, // Restore mask pulse
  input wire logic restore_main_defaults, // Restore main pulse
  output logic [5:0] reg_enable_bits, // Enable bits
  output logic [17:0] slot_codes, // Slot codes
  output logic ext_dvs_control, // Pin picks set
  output logic ext_sleep_control, // Pin drives sleep
  output logic serial_high_set, // Serial set choice
  output logic serial_sleep, // Serial sleep
  output logic [1:0] int_mask, // Interrupt masks
  output logic int_read // Interrupt read pulse
);
  logic busy;
  ////////////////////////////////////////////////////////////////////////////
  // Writes are held back while a sequence runs
  assign busy = power_mode inside {st_bias, st_startup, st_shutdown,
    st_restore_aux, st_restore_main};
  // Idle register image until the first load
  initial begin
    reg_enable_bits = 6'h00;
    slot_codes = 18'h3ffff;
    {ext_dvs_control, ext_sleep_control, serial_high_set} = 3'h0;
    serial_sleep = 1'b0;
    int_mask = 2'h3;
    int_read = 1'b0;
  end
  // Register defaults reloaded on the sequencer's load pulses
  always @(negedge sys_clk) begin
    if (defaults_load || restore_main_defaults) begin
      reg_enable_bits = (default_profile == profile_two) ? 6'h04 : 6'h0f;
      slot_codes = (default_profile == profile_two) ? 18'h3fe3f
        : 18'h3f000;
    end
    if (defaults_load || restore_aux_defaults) begin
      int_mask = 2'h3;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Configuration write, only outside sequences
  task automatic write_cfg(input logic [5:0] en, input logic [17:0] sl);
    wait (!busy);
    @(negedge sys_clk);
    reg_enable_bits = en;
    slot_codes = sl;
  endtask : write_cfg
  // Control and mask write
  task automatic set_ctl(input logic d, input logic s, input logic h,
    input logic q, input logic [1:0] m);
    wait (!busy);
    @(negedge sys_clk);
    {ext_dvs_control, ext_sleep_control, serial_high_set} = {d, s, h};
    serial_sleep = q;
    int_mask = m;
  endtask : set_ctl
  // Read of the interrupt register, one-cycle pulse
  task automatic read_int();
    @(negedge sys_clk);
    int_read = 1'b1;
    @(negedge sys_clk);
    int_read = 1'b0;
  endtask : read_int
endmodule : host_model
`default_nettype wire

// File: verification/test_pmu_mode_sequencer.sv
// Testbench for the power mode sequencer
`timescale 1ns/1ps
`default_nettype none

module test_pmu_mode_sequencer;
  import pmu_seq_pkg::*;
  localparam int BIAS = 20;
  localparam int STEP = 2501;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic battery_supply_ok = 1'b0;
  logic enable_pin = 1'b0;
  logic thermal_trip = 1'b0;
  logic thermal_early_warning = 1'b0;
  logic voltage_set_select = 1'b0;
  logic default_profile_strap_high = 1'b0;
  logic default_profile_strap_low = 1'b0;
  logic bus_address_strap_high = 1'b0;
  logic bus_address_strap_low = 1'b0;
  logic [5:0] reg_enable_bits, regulator_on;
  logic [17:0] slot_codes;
  logic ext_dvs_control, ext_sleep_control, serial_high_set, serial_sleep;
  logic int_read, defaults_load, restore_aux_defaults, restore_main_defaults;
  logic use_high_set, sleep_active, irq_n_out, irq_n_oe;
  logic [1:0] int_mask, int_flags, thermal_status;
  logic [6:0] bus_address;
  mode_t power_mode;
  profile_t default_profile;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last = 0;
  int aux_cyc = 0;
  int main_cyc = 0;
  int load_cyc = 0;
  ////////////////////////////////////////////////////////////////////////////
  pmu_mode_sequencer #(.NUM_REGS(6), .BIAS_CYCLES(BIAS)) u_pmu_mode_sequencer (
    .sys_clk, .rstn, .battery_supply_ok, .enable_pin, .thermal_trip,
    .thermal_early_warning, .voltage_set_select, .default_profile_strap_high,
    .default_profile_strap_low, .bus_address_strap_high,
    .bus_address_strap_low, .reg_enable_bits, .slot_codes, .ext_dvs_control,
    .ext_sleep_control, .serial_high_set, .serial_sleep, .int_mask,
    .int_read, .power_mode, .regulator_on, .defaults_load, .default_profile,
    .bus_address, .restore_aux_defaults, .restore_main_defaults,
    .use_high_set, .sleep_active, .irq_n_out, .irq_n_oe, .int_flags,
    .thermal_status);
  host_model u_host_model (
    .sys_clk, .power_mode, .default_profile, .defaults_load,
    .restore_aux_defaults, .restore_main_defaults, .reg_enable_bits,
    .slot_codes, .ext_dvs_control, .ext_sleep_control, .serial_high_set,
    .serial_sleep, .int_mask, .int_read);
  // Clock, cycle count and pulse time stamps
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (restore_aux_defaults) aux_cyc <= cyc;
    if (restore_main_defaults) main_cyc <= cyc;
    if (defaults_load) load_cyc <= cyc;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Wait for a mode under a bound and stamp the cycle
  task automatic wait_mode(input mode_t m, input int max);
    int n;
    n = 0;
    while (power_mode !== m && n < max) begin
      @(negedge sys_clk);
      n++;
    end
    check(power_mode, m);
    last = cyc;
  endtask : wait_mode
  // Wait for the next regulator change, check value and spacing
  task automatic next_on(input logic [5:0] exp, input int gap);
    logic [5:0] old;
    int n;
    old = regulator_on;
    n = 0;
    while (regulator_on === old && n < gap + 3000) begin
      @(negedge sys_clk);
      n++;
    end
    check(regulator_on, exp);
    if (gap > 0) check(cyc - last, gap);
    last = cyc;
  endtask : next_on
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  // Supply cycling with every strap level: low, floating, high
  task automatic test_por();
    logic [6:0] addr [3];
    profile_t prof [3];
    int t0;
    addr = '{7'h7d, 7'h7c, 7'h7f};
    prof = '{profile_two, profile_three, profile_one};
    for (int i = 0; i < 3; i++) begin
      battery_supply_ok = 1'b0;
      {default_profile_strap_high, bus_address_strap_high} = {2{i == 2}};
      {default_profile_strap_low, bus_address_strap_low} = {2{i == 0}};
      repeat (10) @(negedge sys_clk);
      battery_supply_ok = 1'b1;
      t0 = cyc;
      wait_mode(st_standby, 60);
      @(negedge sys_clk);
      check(load_cyc > t0, 1'b1);
      check(bus_address, addr[i]);
      check(default_profile, prof[i]);
      check(regulator_on, 6'h00);
    end
    $display("test_por done");
  endtask : test_por
  // Start-up with slots set by the host in standby
  task automatic test_startup();
    u_host_model.write_cfg(6'h2f, 18'h0ff90);
    enable_pin = 1'b1;
    wait_mode(st_bias, 10);
    check(regulator_on, 6'h00);
    next_on(6'h01, BIAS + 1);
    next_on(6'h21, STEP);
    next_on(6'h23, STEP);
    next_on(6'h27, 4 * STEP);
    wait_mode(st_idle, 10);
    repeat (3) @(negedge sys_clk);
    check(regulator_on, 6'h2f);
    $display("test_startup done");
  endtask : test_startup
  // Set choice and sleep by pin and by serial setting
  task automatic test_modes();
    logic [6:0] tab [4];
    tab = '{7'b1110010, 7'b1101001, 7'b0001010, 7'b0010101};
    foreach (tab[i]) begin
      u_host_model.set_ctl(tab[i][6], tab[i][5], tab[i][3], tab[i][2], 2'h1);
      voltage_set_select = tab[i][4];
      repeat (8) @(negedge sys_clk);
      check(use_high_set, tab[i][1]);
      check(sleep_active, tab[i][0]);
    end
    u_host_model.set_ctl(1'b0, 1'b0, 1'b0, 1'b0, 2'h1);
    $display("test_modes done");
  endtask : test_modes
  // Masked warning, unmasked trip, shut-down and restart on cooling
  task automatic test_thermal();
    int t0;
    thermal_early_warning = 1'b1;
    repeat (8) @(negedge sys_clk);
    check(int_flags, 2'h1);
    check(irq_n_oe, 1'b0);
    thermal_trip = 1'b1;
    wait_mode(st_shutdown, 10);
    repeat (2) @(negedge sys_clk);
    check({thermal_status, int_flags, irq_n_oe, irq_n_out}, 6'h3e);
    check(regulator_on, 6'h27);
    u_host_model.read_int();
    repeat (2) @(negedge sys_clk);
    check(irq_n_oe, 1'b0);
    next_on(6'h23, STEP);
    next_on(6'h21, 4 * STEP);
    next_on(6'h01, STEP);
    next_on(6'h00, STEP);
    t0 = last;
    wait_mode(st_standby, 3 * STEP);
    @(negedge sys_clk);
    check(aux_cyc - t0, STEP);
    check(main_cyc - aux_cyc, STEP);
    thermal_trip = 1'b0;
    wait_mode(st_bias, 10);
    next_on(6'h0f, BIAS + 1);
    wait_mode(st_idle, 7 * STEP);
    $display("test_thermal done");
  endtask : test_thermal
  // Enable falling with an unsequenced regulator switched on
  task automatic test_shutdown();
    u_host_model.write_cfg(6'h1f, 18'h3f000);
    repeat (3) @(negedge sys_clk);
    check(regulator_on, 6'h1f);
    enable_pin = 1'b0;
    wait_mode(st_shutdown, 10);
    repeat (2) @(negedge sys_clk);
    check(regulator_on, 6'h0f);
    next_on(6'h00, 7 * STEP);
    wait_mode(st_standby, 3 * STEP);
    @(negedge sys_clk);
    check(main_cyc - aux_cyc, STEP);
    $display("test_shutdown done");
  endtask : test_shutdown
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    test_por();
    test_startup();
    test_modes();
    test_thermal();
    test_shutdown();
    finish_test();
  end
  // Watchdog against a hung sequence
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    finish_test();
  end
endmodule : test_pmu_mode_sequencer
`default_nettype wire
